//--- pkg/irq_vec_pkg.sv
// package: offsets, field positions, reset values and states of the interrupt vectoring block
// How it works
// - any reset clears all enables so no vectoring happens until software sets them
// - a source vectors only with global, own and (peripheral) group enable all set
// - the one 32-bit peripheral flag register latches events regardless of any enable bit
// - on acceptance the prefetched instruction is flushed, then global enable cleared
// - on acceptance the pc is pushed and core registers are copied to shadows
// - after saving context the pc is loaded with vector address 0004h
// - with global enable clear, new events set flags and can wake a sleeping core, never redirect flow
// - return from handler pops pc, restores shadows and sets global enable
// - a request pending while global enable is clear is serviced once it is set
// - enabled sources wake the controller from sleep
// - peripheral sources need the group enable as well as their own enable
// - external pin flags on rising edge when polarity is one, falling when zero
// - on wake the next instruction runs first; vector only if global enable set
package irq_vec_pkg;
    localparam int unsigned AW = 8;
    localparam logic [AW-1:0] ADDR_CTRL = 8'h00;
    localparam logic [AW-1:0] ADDR_EN0 = 8'h04;
    localparam logic [AW-1:0] ADDR_FLAG0 = 8'h08;
    localparam logic [AW-1:0] ADDR_EN1 = 8'h10;
    localparam logic [AW-1:0] ADDR_FLAG1 = 8'h20;
    localparam logic [AW-1:0] ADDR_STAT = 8'h30;
    localparam logic [AW-1:0] ADDR_IEN = 8'h34;
    localparam logic [AW-1:0] ADDR_ICLR = 8'h38;
    localparam int unsigned CTRL_GIE = 7;
    localparam int unsigned CTRL_GRP = 6;
    localparam int unsigned CTRL_POL = 0;
    localparam logic [7:0] CTRL_RESET = 8'h01;
    localparam int unsigned FLAG_INT = 0;
    localparam int unsigned NPER = 4;
    localparam logic [15:0] VECTOR_ADDR = 16'h0004;
    localparam int unsigned ST_ACCEPT = 0;
    localparam int unsigned ST_RETURN = 1;
    localparam int unsigned ST_WAKE = 2;
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_FLUSH = 2'b01,
        SEQ_SAVE = 2'b10,
        SEQ_JUMP = 2'b11
    } seq_t;
endpackage

//--- design/pin_edge_detect.sv
// pin synchroniser with polarity-selected edge pulse
module pin_edge_detect (
    input wire logic clk,
    input wire logic srst,
    input wire logic pinIn,
    input wire logic risingSel,
    output logic edgePulse
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } st_t;
    st_t stReg;
    st_t stNext;
    always_comb begin
        stNext = stReg;
        stNext.s1 = pinIn;
        stNext.s2 = stReg.s1;
        stNext.s3 = stReg.s2;
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            stReg <= '0;
        end else begin
            stReg <= stNext;
        end
    end
    // rising when polarity one, falling when zero
    assign edgePulse = risingSel ? (stReg.s2 & ~stReg.s3) : (~stReg.s2 & stReg.s3);
endmodule // pin_edge_detect

//--- design/wb_reg_slave.sv
// classic wishbone slave handshake and read/write strobe helper
module wb_reg_slave (
    input wire logic clk,
    input wire logic srst,
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic wbWe,
    output logic wbAck,
    output logic wrStrobe,
    output logic rdStrobe
);
    typedef struct packed {
        logic ack;
    } st_t;
    st_t stReg;
    st_t stNext;
    logic req;
    assign req = wbCyc & wbStb & ~stReg.ack;
    always_comb begin
        stNext = stReg;
        stNext.ack = req;
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            stReg <= '0;
        end else begin
            stReg <= stNext;
        end
    end
    assign wbAck = stReg.ack;
    // write takes effect on the edge where ack is seen high
    assign wrStrobe = stReg.ack & wbCyc & wbStb & wbWe;
    assign rdStrobe = req & ~wbWe;
endmodule // wb_reg_slave

//--- design/core_interrupt_vectoring.sv
// interrupt flags, enables and vectoring sequence toward the processor core
module core_interrupt_vectoring (
    input wire logic clk,
    input wire logic srst,
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic wbWe,
    input wire logic [irq_vec_pkg::AW-1:0] wbAdr,
    input wire logic [3:0] wbSel,
    input wire logic [31:0] wbDatI,
    output logic [31:0] wbDatO,
    output logic wbAck,
    input wire logic extIntPin,
    input wire logic [7:0] coreEvents,
    input wire logic [31:0] periphEvents,
    input wire logic [15:0] corePc,
    input wire logic [31:0] coreContext,
    input wire logic returnFromHandler,
    input wire logic [15:0] stackTop,
    input wire logic coreSleeping,
    output logic prefetchFlush,
    output logic stackPush,
    output logic [15:0] pushPc,
    output logic stackPop,
    output logic pcLoad,
    output logic [15:0] pcLoadValue,
    output logic [31:0] shadowContext,
    output logic contextRestore,
    output logic wakeUp,
    output logic vectorAfterWake,
    output logic irqOut
);
    import irq_vec_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic globalIrqEnable;
        logic peripheralGroupEnable;
        logic edgePolaritySelect;
        logic [7:0] coreEnable;
        logic [7:0] coreFlags;
        logic [31:0] periphEnable;
        logic [31:0] periphFlags;
        seq_t seq;
        logic [15:0] savedPc;
        logic [31:0] shadow;
        logic [2:0] status;
        logic [2:0] statusEn;
        logic [31:0] rdData;
        logic prefetchFlush;
        logic stackPush;
        logic stackPop;
        logic pcLoad;
        logic [15:0] pcLoadValue;
        logic contextRestore;
        logic wakeUp;
        logic vectorAfterWake;
    } st_t;

    st_t r;
    st_t n;
    logic wrStrobe;
    logic rdStrobe;
    logic pinEdge;
    logic [7:0] coreSet;
    logic corePending;
    logic periphPending;
    logic request;
    logic anyEnabled;

    wb_reg_slave u_bus (
        .clk(clk),
        .srst(srst),
        .wbCyc(wbCyc),
        .wbStb(wbStb),
        .wbWe(wbWe),
        .wbAck(wbAck),
        .wrStrobe(wrStrobe),
        .rdStrobe(rdStrobe)
    );

    pin_edge_detect u_pin (
        .clk(clk),
        .srst(srst),
        .pinIn(extIntPin),
        .risingSel(r.edgePolaritySelect),
        .edgePulse(pinEdge)
    );

    // byte-lane merge of a write into a 32-bit word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[8*i +: 8] = d[8*i +: 8];
            end
        end
        return res;
    endfunction

    // flag update: clear by write of zero, set by event wins
    function automatic logic [31:0] flagUpd(input logic [31:0] old, input logic [31:0] wr, input logic doWr,
                                             input logic [31:0] ev);
        logic [31:0] res;
        res = doWr ? wr : old;
        return res | ev;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    assign coreSet = coreEvents | {7'h00, pinEdge};
    assign corePending = |(r.coreFlags & r.coreEnable);
    assign periphPending = r.peripheralGroupEnable & |(r.periphFlags & r.periphEnable);
    assign request = r.globalIrqEnable & (corePending | periphPending);
    assign anyEnabled = corePending | periphPending;

    always_comb begin
        logic [31:0] wv;
        logic [2:0] ev;
        logic [31:0] fv;
        wv = 32'h0;
        ev = 3'h0;
        fv = 32'h0;
        n = r;
        n.prefetchFlush = 1'b0;
        n.stackPush = 1'b0;
        n.stackPop = 1'b0;
        n.pcLoad = 1'b0;
        n.contextRestore = 1'b0;
        n.wakeUp = 1'b0;
        n.vectorAfterWake = 1'b0;

        // register writes
        if (wrStrobe) begin
            unique case (wbAdr)
                ADDR_CTRL: begin
                    wv = merge({24'h0, r.globalIrqEnable, r.peripheralGroupEnable, 5'h00, r.edgePolaritySelect},
                               wbDatI, wbSel);
                    n.globalIrqEnable = wv[CTRL_GIE];
                    n.peripheralGroupEnable = wv[CTRL_GRP];
                    n.edgePolaritySelect = wv[CTRL_POL];
                end
                ADDR_EN0: begin
                    wv = merge({24'h0, r.coreEnable}, wbDatI, wbSel);
                    n.coreEnable = wv[7:0];
                end
                ADDR_EN1: begin
                    n.periphEnable = merge(r.periphEnable, wbDatI, wbSel);
                end
                ADDR_IEN: begin
                    wv = merge({29'h0, r.statusEn}, wbDatI, wbSel);
                    n.statusEn = wv[2:0];
                end
                default: begin
                end
            endcase
        end

        // flags latch whatever the enables say; firmware clears them
        fv = flagUpd({24'h0, r.coreFlags}, merge({24'h0, r.coreFlags}, wbDatI, wbSel),
                     wrStrobe && wbAdr == ADDR_FLAG0, {24'h0, coreSet});
        n.coreFlags = fv[7:0];
        n.periphFlags = flagUpd(r.periphFlags, merge(r.periphFlags, wbDatI, wbSel),
                                wrStrobe && wbAdr == ADDR_FLAG1, periphEvents);

        // vectoring sequence
        unique case (r.seq)
            SEQ_IDLE: begin
                if (returnFromHandler) begin
                    n.stackPop = 1'b1;
                    n.pcLoad = 1'b1;
                    n.pcLoadValue = stackTop;
                    n.contextRestore = 1'b1;
                    n.globalIrqEnable = 1'b1;
                    ev[ST_RETURN] = 1'b1;
                end else if (coreSleeping && anyEnabled && !r.wakeUp) begin
                    // one pulse only; the core leaves sleep a cycle after seeing it
                    // next instruction runs first; vectoring follows only via request
                    n.wakeUp = 1'b1;
                    n.vectorAfterWake = r.globalIrqEnable;
                    ev[ST_WAKE] = 1'b1;
                end else if (request && !coreSleeping) begin
                    // pending flags still set when enable returns are taken here
                    n.prefetchFlush = 1'b1;
                    n.savedPc = corePc;
                    n.seq = SEQ_FLUSH;
                    ev[ST_ACCEPT] = 1'b1;
                end
            end
            SEQ_FLUSH: begin
                n.globalIrqEnable = 1'b0;
                n.seq = SEQ_SAVE;
            end
            SEQ_SAVE: begin
                n.stackPush = 1'b1;
                n.shadow = coreContext;
                n.seq = SEQ_JUMP;
            end
            SEQ_JUMP: begin
                n.pcLoad = 1'b1;
                n.pcLoadValue = VECTOR_ADDR;
                n.seq = SEQ_IDLE;
            end
        endcase

        // sticky status, set wins over clear
        n.status = (r.status & ~((wrStrobe && wbAdr == ADDR_ICLR && wbSel[0]) ? wbDatI[2:0] : 3'h0)) | ev;

        // read mux
        n.rdData = 32'h0;
        if (rdStrobe) begin
            unique case (wbAdr)
                ADDR_CTRL: n.rdData = {24'h0, r.globalIrqEnable, r.peripheralGroupEnable, 5'h00,
                                       r.edgePolaritySelect};
                ADDR_EN0: n.rdData = {24'h0, r.coreEnable};
                ADDR_FLAG0: n.rdData = {24'h0, r.coreFlags};
                ADDR_EN1: n.rdData = r.periphEnable;
                ADDR_FLAG1: n.rdData = r.periphFlags;
                ADDR_STAT: n.rdData = {29'h0, r.status};
                ADDR_IEN: n.rdData = {29'h0, r.statusEn};
                default: n.rdData = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            r <= '0;
            r.edgePolaritySelect <= CTRL_RESET[CTRL_POL];
        end else begin
            r <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign wbDatO = r.rdData;
    assign prefetchFlush = r.prefetchFlush;
    assign stackPush = r.stackPush;
    assign pushPc = r.savedPc;
    assign stackPop = r.stackPop;
    assign pcLoad = r.pcLoad;
    assign pcLoadValue = r.pcLoadValue;
    assign shadowContext = r.shadow;
    assign contextRestore = r.contextRestore;
    assign wakeUp = r.wakeUp;
    assign vectorAfterWake = r.vectorAfterWake;
    assign irqOut = |(r.status & r.statusEn);
endmodule // core_interrupt_vectoring

//--- tb/irq_vec_sva.sv
// checker: timing relations of the vectoring sequence and bus handshake
module irq_vec_sva (
    input wire logic clk,
    input wire logic srst,
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic wbAck,
    input wire logic [15:0] stackTop,
    input wire logic coreSleeping,
    input wire logic prefetchFlush,
    input wire logic stackPush,
    input wire logic stackPop,
    input wire logic pcLoad,
    input wire logic [15:0] pcLoadValue,
    input wire logic contextRestore,
    input wire logic wakeUp,
    input wire logic vectorAfterWake
);
    import irq_vec_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    ////////////////////////////////////////////////////////////////////////
    a_reset_quiet: assert property (disable iff (1'b0) srst |=> !prefetchFlush && !stackPush && !pcLoad)
        else $error("core strobes active after reset");
    a_flush_push: assert property (prefetchFlush |-> ##2 stackPush)
        else $error("push not two cycles after flush");
    a_push_vector: assert property (stackPush |=> pcLoad && pcLoadValue == VECTOR_ADDR)
        else $error("vector not loaded after push");
    a_seq_closed: assert property (prefetchFlush |=> !prefetchFlush [*3])
        else $error("second acceptance inside sequence");
    a_return_pop: assert property (stackPop |-> pcLoad && contextRestore && pcLoadValue == $past(stackTop))
        else $error("return did not restore pc and context");
    a_wake_sleep: assert property (wakeUp |-> $past(coreSleeping) && !prefetchFlush)
        else $error("wake without sleep");
    a_wake_vec: assert property (vectorAfterWake |-> wakeUp)
        else $error("vector flag without wake");
    a_wake_single: assert property (wakeUp |=> !wakeUp)
        else $error("wake pulse longer than one cycle");
    a_flush_awake: assert property (prefetchFlush |-> !$past(coreSleeping))
        else $error("acceptance while asleep");
    a_ack_pulse: assert property (wbCyc && wbStb && !wbAck |=> wbAck ##1 !wbAck)
        else $error("bus ack not a one cycle answer");
    c_accept: cover property (prefetchFlush ##3 pcLoad);
    c_return: cover property (stackPop);
    c_wake: cover property (wakeUp);
endmodule // irq_vec_sva
bind core_interrupt_vectoring irq_vec_sva sva (.*);

//--- tb/core_model.sv
// core model: program counter, one-deep return stack and sleep state
module core_model #(
    parameter logic [31:0] CTX = 32'h5a5ac3c3
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic sleepReq,
    input wire logic retReq,
    input wire logic stackPush,
    input wire logic [15:0] pushPc,
    input wire logic pcLoad,
    input wire logic [15:0] pcLoadValue,
    input wire logic wakeUp,
    output logic [15:0] corePc,
    output logic [15:0] stackTop,
    output logic [31:0] coreContext,
    output logic returnFromHandler,
    output logic coreSleeping
);
    timeunit 1ns;
    timeprecision 1ns;
    assign coreContext = CTX;
    assign returnFromHandler = retReq;
    always_ff @(posedge clk) begin
        if (srst) begin
            corePc <= 16'h0100;
            stackTop <= 16'h0000;
            coreSleeping <= 1'b0;
        end else begin
            if (pcLoad) begin
                corePc <= pcLoadValue;
            end else if (!coreSleeping) begin
                corePc <= corePc + 16'h0001;
            end
            if (stackPush) begin
                stackTop <= pushPc;
            end
            if (wakeUp) begin
                coreSleeping <= 1'b0;
            end else if (sleepReq) begin
                coreSleeping <= 1'b1;
            end
        end
    end
endmodule // core_model

//--- tb/tb.sv
// testbench: register access, acceptance, return, pin edge and wake tests
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import irq_vec_pkg::*;
    localparam logic [31:0] CTX = 32'h5a5ac3c3;
    logic clk = 0, srst = 1, wbCyc = 0, wbStb = 0, wbWe = 0, extIntPin = 0, retReq = 0, sleepReq = 0;
    logic [AW-1:0] wbAdr = '0;
    logic [3:0] wbSel = 4'h0;
    logic [31:0] wbDatI = '0, periphEvents = '0, wbDatO, coreContext, shadowContext, q;
    logic [7:0] coreEvents = 8'h00;
    logic [15:0] corePc, stackTop, pushPc, pcLoadValue;
    logic wbAck, returnFromHandler, coreSleeping, prefetchFlush, stackPush, stackPop, pcLoad;
    logic contextRestore, wakeUp, vectorAfterWake, irqOut;
    logic [15:0] lastLoad = '0;
    int error_cnt = 0, compares = 0, cycles = 0, flushCnt = 0, wakeCnt = 0, vawCnt = 0, popCnt = 0;
    core_interrupt_vectoring dut (.*);
    core_model #(.CTX(CTX)) core (.*);
    initial forever #20 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (prefetchFlush === 1'b1) flushCnt++;
        if (wakeUp === 1'b1) wakeCnt++;
        if (vectorAfterWake === 1'b1) vawCnt++;
        if (stackPop === 1'b1 && contextRestore === 1'b1) popCnt++;
        if (pcLoad === 1'b1) lastLoad <= pcLoadValue;
        if (cycles > 3000) begin
            error_cnt++;
            complete_run();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic xfer(input logic we, input logic [AW-1:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= a;
        wbDatI <= d;
        wbSel <= 4'hf;
        do begin
            @(posedge clk);
            n++;
        end while (wbAck !== 1'b1 && n < 20);
        q = wbDatO;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        if (n >= 20) chk("ack", 1, 0);
    endtask
    task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rd(input string n, input logic [AW-1:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(n, e, q);
    endtask
    task automatic pulse(input logic [7:0] c, input logic [31:0] p, input logic r, input logic s);
        @(posedge clk);
        coreEvents <= c;
        periphEvents <= p;
        retReq <= r;
        sleepReq <= s;
        @(posedge clk);
        coreEvents <= 8'h00;
        periphEvents <= 32'h0;
        retReq <= 1'b0;
        sleepReq <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        rd("ctrl", ADDR_CTRL, {24'h0, CTRL_RESET});
        rd("en1", ADDR_EN1, 32'h0);
        rd("unmapped", 8'hfc, 32'h0);
        $display("test reset done");
        pulse(8'h02, 32'h80402010, 1'b0, 1'b0);
        rd("flag1", ADDR_FLAG1, 32'h80402010);
        rd("flag0", ADDR_FLAG0, 32'h2);
        $display("test flags done");
        wr(ADDR_FLAG0, 32'h0);
        wr(ADDR_EN1, 32'hffffffff);
        wr(ADDR_EN0, 32'h2);
        wr(ADDR_IEN, 32'h1);
        wr(ADDR_CTRL, 32'h81);
        repeat (8) @(posedge clk);
        chk("flush", 0, flushCnt);
        wr(ADDR_CTRL, 32'hc1);
        repeat (8) @(posedge clk);
        chk("flush", 1, flushCnt);
        chk("shadow", CTX, shadowContext);
        chk("vector", {16'h0, VECTOR_ADDR}, {16'h0, lastLoad});
        rd("ctrl", ADDR_CTRL, 32'h41);
        rd("stat", ADDR_STAT, 32'h1);
        chk("irq", 1, irqOut);
        wr(ADDR_ICLR, 32'h1);
        @(posedge clk);
        chk("irq", 0, irqOut);
        $display("test accept done");
        pulse(8'h02, 32'h0, 1'b0, 1'b0);
        repeat (8) @(posedge clk);
        chk("flush", 1, flushCnt);
        rd("flag0", ADDR_FLAG0, 32'h2);
        wr(ADDR_FLAG1, 32'h0);
        pulse(8'h00, 32'h0, 1'b1, 1'b0);
        repeat (8) @(posedge clk);
        chk("flush", 2, flushCnt);
        wr(ADDR_FLAG0, 32'h0);
        pulse(8'h00, 32'h0, 1'b1, 1'b0);
        repeat (8) @(posedge clk);
        chk("flush", 2, flushCnt);
        chk("pop", 2, popCnt);
        chk("retpc", {16'h0, stackTop}, {16'h0, lastLoad});
        rd("ctrl", ADDR_CTRL, 32'hc1);
        $display("test return done");
        for (int p = 0; p < 2; p++) begin
            wr(ADDR_CTRL, p);
            extIntPin <= p[0];
            repeat (4) @(posedge clk);
            wr(ADDR_FLAG0, 32'h0);
            extIntPin <= !p[0];
            repeat (4) @(posedge clk);
            rd("pin", ADDR_FLAG0, 32'h0);
            extIntPin <= p[0];
            repeat (4) @(posedge clk);
            rd("pin", ADDR_FLAG0, 32'h1);
        end
        $display("test pin done");
        wr(ADDR_EN0, 32'h1);
        pulse(8'h00, 32'h0, 1'b0, 1'b1);
        repeat (6) @(posedge clk);
        chk("wake", 1, wakeCnt);
        chk("vaw", 0, vawCnt);
        chk("flush", 2, flushCnt);
        wr(ADDR_FLAG0, 32'h0);
        wr(ADDR_CTRL, 32'h81);
        pulse(8'h00, 32'h0, 1'b0, 1'b1);
        pulse(8'h01, 32'h0, 1'b0, 1'b0);
        repeat (8) @(posedge clk);
        chk("wake", 2, wakeCnt);
        chk("vaw", 1, vawCnt);
        chk("flush", 3, flushCnt);
        $display("test wake done");
        complete_run();
    end
endmodule // tb
